// ===== hdl/rvs_regs.svh
// Offsets, fields, resets and timing of the voltage supervisor
// Functional notes
// - Low trip fuse: 95, 93, 91, 89 percent
// - High trip fuse: 105, 107, 109, 111 percent
// - Shared low filter: 5, 15, 25, 40 us
// - Low filter resets to binary 10
// - Shared high filter: 25, 50, 80, 125 us
// - High filter resets to binary 00
// - Own supervise enable per output
// - Supervise enables reset to one
// - Secure mode ignores plain enable writes
// - Turned-on output masked until regulated
// - Disabled output's trip states forced to zero
// - Reference mismatch blocks buck power-up
// - Mismatch while on, notify fuse 0: stages off
// - Mismatch while on, notify fuse 1: interrupt only
// - Sticky flag drives interrupt pin when unmasked
// - Live reference state: 0 in range, 1 out
// - Seven buck, four linear outputs, each independent
// - Filters timed by a 100 kHz tick
`ifndef RVS_REGS_SVH
`define RVS_REGS_SVH

// ----------------------------------------------------------------------------
// Channel layout
// ----------------------------------------------------------------------------
`define RVS_NCH          11
`define RVS_PCT_W        7
`define RVS_CNT_W        4
// Synchronised pin bundle: uv, ov, on, regulated, ref mismatch, system on
`define RVS_PIN_W        46
`define RVS_PIN_UV       0
`define RVS_PIN_OV       11
`define RVS_PIN_ON       22
`define RVS_PIN_OK       33
`define RVS_PIN_REF      44
`define RVS_PIN_SYS      45

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RVS_OFS_CTRL     6'h00
`define RVS_OFS_SUPON    6'h04
`define RVS_OFS_SECSUP   6'h08
`define RVS_OFS_UNLOCK   6'h0c
`define RVS_OFS_LOWST    6'h10
`define RVS_OFS_HIGHST   6'h14
`define RVS_OFS_REF      6'h18
`define RVS_OFS_FUSE     6'h1c
`define RVS_UNLOCK_KEY   32'h5ec0_0e11

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define RVS_CTRL_LOW     1:0
`define RVS_CTRL_HIGH    3:2
`define RVS_CTRL_SEC     4
`define RVS_REF_FLAG     1
`define RVS_REF_MASK     2
`define RVS_LOW_SEL_RST  2'h2
`define RVS_HIGH_SEL_RST 2'h0
`define RVS_SUPON_RST    11'h7ff

// ----------------------------------------------------------------------------
// Trip percentages and filter times
// ----------------------------------------------------------------------------
`define RVS_LOW_PCT0     7'h5f
`define RVS_LOW_PCT1     7'h5d
`define RVS_LOW_PCT2     7'h5b
`define RVS_LOW_PCT3     7'h59
`define RVS_HIGH_PCT0    7'h69
`define RVS_HIGH_PCT1    7'h6b
`define RVS_HIGH_PCT2    7'h6d
`define RVS_HIGH_PCT3    7'h6f
`define RVS_CLK_HZ       125000000
`define RVS_TICK_HZ      100000
`define RVS_TICK_NS      10000
`define RVS_LOW_NS0      5000
`define RVS_LOW_NS1      15000
`define RVS_LOW_NS2      25000
`define RVS_LOW_NS3      40000
`define RVS_HIGH_NS0     25000
`define RVS_HIGH_NS1     50000
`define RVS_HIGH_NS2     80000
`define RVS_HIGH_NS3     125000

`endif

// ===== hdl/rvs_pkg.sv
// Types and decode functions of the voltage supervisor
`include "rvs_regs.svh"
package rvs_pkg;

   // Filter time in whole ticks, rounded up, never below one
   function automatic logic [`RVS_CNT_W-1:0] rvs_ticks(input int ns);
      int t;
      t = (ns + `RVS_TICK_NS - 1) / `RVS_TICK_NS;
      if (t < 1)
      begin
         t = 1;
      end
      return t[`RVS_CNT_W-1:0];
   endfunction

   // Top-level state: one packed struct
   typedef struct packed {
      logic                        ack;
      logic [31:0]                 rdat;
      logic [1:0]                  low_sel;
      logic [1:0]                  high_sel;
      logic                        sec_en;
      logic                        armed;
      logic [`RVS_NCH-1:0]         sup_on;
      logic [`RVS_NCH-1:0]         mask;
      logic [`RVS_PIN_W-1:0]       s1;
      logic [`RVS_PIN_W-1:0]       s2;
      logic [`RVS_PIN_W-1:0]       s3;
      logic [`RVS_PIN_W-1:0]       pin;
      logic                        ref_prev;
      logic                        ref_flag;
      logic                        ref_mask;
      logic                        stage_off;
      logic                        block;
      logic                        irq_n;
      logic [`RVS_NCH*`RVS_PCT_W-1:0] low_pct;
      logic [`RVS_NCH*`RVS_PCT_W-1:0] high_pct;
   } rvs_top_state_t;

endpackage

// ===== hdl/rvs_filt_if.sv
// Control-to-filter bundle
interface rvs_filt_if #(parameter int N = 11, parameter int CW = 4);
   logic          tick;
   logic [N-1:0]  raw;
   logic [N-1:0]  hold;
   logic [CW-1:0] limit;
   logic [N-1:0]  state;
   modport ctrl (output tick, output raw, output hold, output limit, input state);
   modport filt (input tick, input raw, input hold, input limit, output state);
endinterface

// ===== hdl/rvs_tick.sv
// One-cycle 100 kHz timing enable
module rvs_tick
#(
   parameter int DIV = 1250
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } rvs_tick_state_t;

   rvs_tick_state_t st_r;
   rvs_tick_state_t st_nxt;

   if (DIV < 2 || DIV > 65535)
   begin : g_chk
      $error("rvs_tick: DIV out of range");
   end

   // ----------------------------------------------------------------------
   // Count down and pulse
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 16'h0)
      begin
         st_nxt.cnt  = 16'(DIV - 1);
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt - 16'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick_o = st_r.tick;
endmodule

// ===== hdl/rvs_filt.sv
// Persistence filter, one shared filter time per group
module rvs_filt
#(
   parameter int N  = 11,
   parameter int CW = 4
)
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   rvs_filt_if.filt   fi
);
   typedef struct packed {
      logic [N-1:0][CW-1:0] cnt;
      logic [N-1:0]         state;
   } rvs_filt_state_t;

   rvs_filt_state_t st_r;
   rvs_filt_state_t st_nxt;

   if (N < 1 || CW < 1)
   begin : g_chk
      $error("rvs_filt: bad size");
   end

   // ----------------------------------------------------------------------
   // Per-channel persistence count
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      for (int i = 0; i < N; i++)
      begin
         if (fi.hold[i])
         begin
            st_nxt.cnt[i]   = '0;
            st_nxt.state[i] = 1'b0;
         end
         else if (!fi.raw[i])
         begin
            st_nxt.cnt[i]   = '0;
            st_nxt.state[i] = 1'b0;
         end
         else if (fi.tick && !st_r.state[i])
         begin
            if (st_r.cnt[i] + CW'(1) >= fi.limit)
               st_nxt.state[i] = 1'b1;
            else
               st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign fi.state = st_r.state;
endmodule

// ===== hdl/rvs_top.sv
// Voltage supervisor top: sync, masking, filters, reference check, registers
`include "rvs_regs.svh"
module rvs_top
   import rvs_pkg::*;
#(
   parameter int NCH = `RVS_NCH,
   parameter int DIV = `RVS_CLK_HZ / `RVS_TICK_HZ
)
(
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone classic slave
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [5:0]                    adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [31:0]                   dat_i,
   output logic [31:0]                        dat_o,
   output logic                               ack_o,
   // Fuse codes, two bits per output (static after load)
   input  wire logic [13:0]                   buck_low_trip_fuse_i,
   input  wire logic [7:0]                    linear_low_trip_fuse_i,
   input  wire logic [13:0]                   buck_high_trip_fuse_i,
   input  wire logic [7:0]                    linear_high_trip_fuse_i,
   input  wire logic                          ref_check_notify_only_i,
   // Analog side, asynchronous
   input  wire logic [NCH-1:0]                under_voltage_i,
   input  wire logic [NCH-1:0]                over_voltage_i,
   input  wire logic [NCH-1:0]                reg_on_i,
   input  wire logic [NCH-1:0]                reg_in_regulation_i,
   input  wire logic                          ref_mismatch_i,
   input  wire logic                          system_on_i,
   // Results
   output logic [NCH*`RVS_PCT_W-1:0]          low_trip_pct_o,
   output logic [NCH*`RVS_PCT_W-1:0]          high_trip_pct_o,
   output logic [NCH-1:0]                     low_trip_state_o,
   output logic [NCH-1:0]                     high_trip_state_o,
   output logic                               power_stage_off_o,
   output logic                               buck_start_block_o,
   output logic                               irq_out_n_o
);

   if (NCH != `RVS_NCH)
   begin : g_chk
      $error("rvs_top: NCH fixed by register layout");
   end

   // ----------------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------------
   function automatic logic [`RVS_PCT_W-1:0] low_pct(input logic [1:0] c);
      unique case (c)
         2'h0: low_pct = `RVS_LOW_PCT0;
         2'h1: low_pct = `RVS_LOW_PCT1;
         2'h2: low_pct = `RVS_LOW_PCT2;
         2'h3: low_pct = `RVS_LOW_PCT3;
      endcase
   endfunction

   function automatic logic [`RVS_PCT_W-1:0] high_pct(input logic [1:0] c);
      unique case (c)
         2'h0: high_pct = `RVS_HIGH_PCT0;
         2'h1: high_pct = `RVS_HIGH_PCT1;
         2'h2: high_pct = `RVS_HIGH_PCT2;
         2'h3: high_pct = `RVS_HIGH_PCT3;
      endcase
   endfunction

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      merge = (old & ~m) | (d & m);
   endfunction

   // ----------------------------------------------------------------------
   // State and sub-blocks
   // ----------------------------------------------------------------------
   rvs_top_state_t st_r;
   rvs_top_state_t st_nxt;
   logic           tick;
   logic [31:0]    wr_ctrl;
   logic [31:0]    wr_sup;
   logic [21:0]    low_fuse;
   logic [21:0]    high_fuse;

   rvs_filt_if #(.N(NCH), .CW(`RVS_CNT_W)) low_if ();
   rvs_filt_if #(.N(NCH), .CW(`RVS_CNT_W)) high_if ();

   rvs_tick #(.DIV(DIV)) u_tick
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (tick)
   );

   rvs_filt #(.N(NCH), .CW(`RVS_CNT_W)) u_low
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .fi    (low_if)
   );

   rvs_filt #(.N(NCH), .CW(`RVS_CNT_W)) u_high
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .fi    (high_if)
   );

   // ----------------------------------------------------------------------
   // Filter hookup
   // ----------------------------------------------------------------------
   // hold while disabled or masked
   assign low_if.tick   = tick;
   assign low_if.raw    = st_r.pin[`RVS_PIN_UV +: `RVS_NCH];
   assign low_if.hold   = ~st_r.sup_on | st_r.mask;
   assign high_if.tick  = tick;
   assign high_if.raw   = st_r.pin[`RVS_PIN_OV +: `RVS_NCH];
   assign high_if.hold  = ~st_r.sup_on | st_r.mask;

   always_comb
   begin
      unique case (st_r.low_sel)
         2'h0: low_if.limit = rvs_ticks(`RVS_LOW_NS0);
         2'h1: low_if.limit = rvs_ticks(`RVS_LOW_NS1);
         2'h2: low_if.limit = rvs_ticks(`RVS_LOW_NS2);
         2'h3: low_if.limit = rvs_ticks(`RVS_LOW_NS3);
      endcase
   end

   always_comb
   begin
      unique case (st_r.high_sel)
         2'h0: high_if.limit = rvs_ticks(`RVS_HIGH_NS0);
         2'h1: high_if.limit = rvs_ticks(`RVS_HIGH_NS1);
         2'h2: high_if.limit = rvs_ticks(`RVS_HIGH_NS2);
         2'h3: high_if.limit = rvs_ticks(`RVS_HIGH_NS3);
      endcase
   end

   // Bucks first, then linear outputs
   assign low_fuse  = {linear_low_trip_fuse_i, buck_low_trip_fuse_i};
   assign high_fuse = {linear_high_trip_fuse_i, buck_high_trip_fuse_i};

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic acc;
      logic wr;
      logic bad_rise;
      acc      = 1'b0;
      wr       = 1'b0;
      bad_rise = 1'b0;
      st_nxt   = st_r;
      wr_ctrl  = merge({27'h0, st_r.sec_en, st_r.high_sel, st_r.low_sel}, dat_i, sel_i);
      wr_sup   = merge({21'h0, st_r.sup_on}, dat_i, sel_i);

      // Three-stage sync; a level counts once stages two and three agree
      st_nxt.s1 = {system_on_i, ref_mismatch_i, reg_in_regulation_i, reg_on_i,
                   over_voltage_i, under_voltage_i};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int b = 0; b < `RVS_PIN_W; b++)
      begin
         if (st_r.s2[b] == st_r.s3[b])
            st_nxt.pin[b] = st_r.s3[b];
      end

      // low trip decode, high trip decode, per channel
      for (int i = 0; i < NCH; i++)
      begin
         st_nxt.low_pct[i*`RVS_PCT_W +: `RVS_PCT_W]  = low_pct(low_fuse[2*i +: 2]);
         st_nxt.high_pct[i*`RVS_PCT_W +: `RVS_PCT_W] = high_pct(high_fuse[2*i +: 2]);
      end

      st_nxt.mask = ~st_r.pin[`RVS_PIN_ON +: `RVS_NCH]
                  | (st_r.mask & ~st_r.pin[`RVS_PIN_OK +: `RVS_NCH]);

      bad_rise        = st_r.pin[`RVS_PIN_REF] & ~st_r.ref_prev;
      st_nxt.ref_prev = st_r.pin[`RVS_PIN_REF];

      // no buck power-up while references disagree
      st_nxt.block = st_r.pin[`RVS_PIN_REF] & ~st_r.pin[`RVS_PIN_SYS];

      // shutdown unless notify-only; notify-only keeps running
      if (st_r.pin[`RVS_PIN_REF] && st_r.pin[`RVS_PIN_SYS] && !ref_check_notify_only_i)
         st_nxt.stage_off = 1'b1;

      // Wishbone: answer one cycle after the request, drop ack right after
      acc        = cyc_i & stb_i & ~st_r.ack;
      wr         = acc & we_i;
      st_nxt.ack = acc;
      if (acc)
      begin
         unique case (adr_i)
            `RVS_OFS_CTRL:   st_nxt.rdat = {27'h0, st_r.sec_en, st_r.high_sel, st_r.low_sel};
            `RVS_OFS_SUPON:  st_nxt.rdat = {21'h0, st_r.sup_on};
            `RVS_OFS_SECSUP: st_nxt.rdat = {21'h0, st_r.sup_on};
            `RVS_OFS_UNLOCK: st_nxt.rdat = {31'h0, st_r.armed};
            `RVS_OFS_LOWST:  st_nxt.rdat = {21'h0, low_if.state};
            `RVS_OFS_HIGHST: st_nxt.rdat = {21'h0, high_if.state};
            `RVS_OFS_REF:    st_nxt.rdat = {27'h0, st_r.block, st_r.stage_off, st_r.ref_mask,
                                            st_r.ref_flag, st_r.pin[`RVS_PIN_REF]};
            `RVS_OFS_FUSE:   st_nxt.rdat = {9'h0, ref_check_notify_only_i, high_fuse};
            default:         st_nxt.rdat = 32'h0;
         endcase
      end

      if (wr)
      begin
         // Any write other than the key write to the unlock offset disarms the secure sequence
         st_nxt.armed = 1'b0;
         unique case (adr_i)
            `RVS_OFS_CTRL:
            begin
               st_nxt.low_sel  = wr_ctrl[`RVS_CTRL_LOW];
               st_nxt.high_sel = wr_ctrl[`RVS_CTRL_HIGH];
               st_nxt.sec_en   = wr_ctrl[`RVS_CTRL_SEC];
            end
            `RVS_OFS_SUPON:
            begin
               if (!st_r.sec_en)
                  st_nxt.sup_on = wr_sup[`RVS_NCH-1:0];
            end
            // secure path needs the key write just before
            `RVS_OFS_SECSUP:
            begin
               if (st_r.armed)
                  st_nxt.sup_on = wr_sup[`RVS_NCH-1:0];
            end
            `RVS_OFS_UNLOCK:
            begin
               st_nxt.armed = (sel_i == 4'hf) && (dat_i == `RVS_UNLOCK_KEY);
            end
            `RVS_OFS_REF:
            begin
               if (sel_i[0] && dat_i[`RVS_REF_FLAG])
                  st_nxt.ref_flag = 1'b0;
               if (sel_i[0])
                  st_nxt.ref_mask = dat_i[`RVS_REF_MASK];
            end
            default:
            begin
               st_nxt.armed = 1'b0;
            end
         endcase
      end

      // sticky flag, set wins over clear
      if (bad_rise)
         st_nxt.ref_flag = 1'b1;

      st_nxt.irq_n = ~(st_nxt.ref_flag & ~st_nxt.ref_mask);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r          <= '0;
         st_r.low_sel  <= `RVS_LOW_SEL_RST;
         st_r.high_sel <= `RVS_HIGH_SEL_RST;
         st_r.sup_on   <= `RVS_SUPON_RST;
         st_r.mask     <= '1;
         st_r.irq_n    <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------------
   assign dat_o              = st_r.rdat;
   assign ack_o              = st_r.ack;
   assign low_trip_pct_o     = st_r.low_pct;
   assign high_trip_pct_o    = st_r.high_pct;
   assign low_trip_state_o   = low_if.state;
   assign high_trip_state_o  = high_if.state;
   assign power_stage_off_o  = st_r.stage_off;
   assign buck_start_block_o = st_r.block;
   assign irq_out_n_o        = st_r.irq_n;

endmodule

// ===== bench/rvs_sva.sv
// Port checker, bound into the supervisor top
module rvs_sva
#(
   parameter int DIV = 4
)
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [13:0] buck_low_trip_fuse_i,
   input wire logic [13:0] buck_high_trip_fuse_i,
   input wire logic        ref_check_notify_only_i,
   input wire logic [10:0] under_voltage_i,
   input wire logic [10:0] over_voltage_i,
   input wire logic [10:0] reg_on_i,
   input wire logic        ref_mismatch_i,
   input wire logic        system_on_i,
   input wire logic [76:0] low_trip_pct_o,
   input wire logic [76:0] high_trip_pct_o,
   input wire logic [10:0] low_trip_state_o,
   input wire logic [10:0] high_trip_state_o,
   input wire logic        power_stage_off_o,
   input wire logic        buck_start_block_o,
   input wire logic        irq_out_n_o
);
   // ---------------------------------------------
   // Relations between pins
   // ---------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] ov_run_r;
   // Raw high-fault run on channel 3, saturating
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !over_voltage_i[3])
         ov_run_r <= 8'h0;
      else if (ov_run_r != 8'hff)
         ov_run_r <= ov_run_r + 8'h1;
   end
   property p_low_pct; !$past(rst_i) && !$past(rst_i, 2) && $stable(buck_low_trip_fuse_i)
      |-> low_trip_pct_o[6:0] == 7'h5f - {4'h0, buck_low_trip_fuse_i[1:0], 1'b0}; endproperty
   a_low_pct: assert property (p_low_pct) else $error("low pct");
   property p_high_pct; !$past(rst_i) && !$past(rst_i, 2) && $stable(buck_high_trip_fuse_i)
      |-> high_trip_pct_o[6:0] == 7'h69 + {4'h0, buck_high_trip_fuse_i[1:0], 1'b0}; endproperty
   a_high_pct: assert property (p_high_pct) else $error("high pct");
   property p_uv_mask; !reg_on_i[5] [*8] |-> !low_trip_state_o[5]; endproperty
   a_uv_mask: assert property (p_uv_mask) else $error("low state while off");
   property p_ov_mask; !reg_on_i[5] [*8] |-> !high_trip_state_o[5]; endproperty
   a_ov_mask: assert property (p_ov_mask) else $error("high state while off");
   property p_persist; $rose(high_trip_state_o[3]) |-> ov_run_r >= 2 * DIV; endproperty
   a_persist: assert property (p_persist) else $error("early high");
   property p_release; !under_voltage_i[3] [*8] |-> !low_trip_state_o[3]; endproperty
   a_release: assert property (p_release) else $error("low state stuck");
   property p_stage; (ref_mismatch_i && system_on_i && !ref_check_notify_only_i) [*8] |-> power_stage_off_o;
   endproperty
   a_stage: assert property (p_stage) else $error("no shutdown");
   property p_notify; $rose(power_stage_off_o) |-> !ref_check_notify_only_i; endproperty
   a_notify: assert property (p_notify) else $error("notify shutdown");
   property p_block; (ref_mismatch_i && !system_on_i) [*8] |-> buck_start_block_o; endproperty
   a_block: assert property (p_block) else $error("start not blocked");
   c_low: cover property ($rose(low_trip_state_o[3]));
   c_off: cover property ($rose(power_stage_off_o));
   c_irq: cover property ($fell(irq_out_n_o));
endmodule
bind rvs_top rvs_sva #(.DIV(DIV)) rvs_sva_i (.*);

// ===== bench/rvs_reg_model.sv
// Regulators and comparators at the far side
module rvs_reg_model
#(
   parameter int RAMP = 40
)
(
   input  wire logic        clk_i,
   input  wire logic [10:0] en_i,
   input  wire logic [10:0] uv_i,
   input  wire logic [10:0] ov_i,
   output logic      [10:0] on_o,
   output logic      [10:0] ok_o,
   output logic      [10:0] uvr_o,
   output logic      [10:0] ovr_o
);
   // ---------------------------------------------
   // Soft-start ramp
   // ---------------------------------------------
   logic [10:0] d [RAMP];
   // Regulated once the ramp runs out
   always @(posedge clk_i)
   begin
      d[0] <= en_i;
      for (int k = 1; k < RAMP; k++)
         d[k] <= d[k-1] & en_i;
   end
   assign on_o  = en_i;
   assign ok_o  = d[RAMP-1] & en_i;
   // A switched-off output sags, so its low comparator fires
   assign uvr_o = uv_i | ~en_i;
   assign ovr_o = ov_i & en_i;
endmodule

// ===== bench/rvs_top_tb.sv
// Voltage supervisor bench
`include "rvs_regs.svh"
module rvs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4;
   localparam int UVT[4] = '{1, 2, 3, 4};
   localparam int OVT[4] = '{3, 5, 8, 13};
   logic            clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, nf = 1'b1, sys = 1'b0, refb = 1'b0;
   logic [13:0]     bl = 14'h0, bh = 14'h0;
   logic [7:0]      ll = 8'h0, lh = 8'h0;
   logic [10:0]     en = 11'h7ff, uvc = 11'h0, ovc = 11'h0;
   logic [31:0]     wdat = 32'h0;
   logic [5:0]      adr = 6'h0;
   logic [3:0]      sel = 4'hf;
   wire logic [10:0] on, ok, uvr, ovr, ls, hs;
   wire logic [76:0] lp, hp;
   wire logic [31:0] rdat;
   wire logic       ack, soff, blk, irqn;
   int              fails = 0, comparisons = 0;
   // ---------------------------------------------
   // Design and far side
   // ---------------------------------------------
   rvs_top #(.DIV(DIV)) rvs_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .buck_low_trip_fuse_i(bl),
      .linear_low_trip_fuse_i(ll), .buck_high_trip_fuse_i(bh), .linear_high_trip_fuse_i(lh),
      .ref_check_notify_only_i(nf), .under_voltage_i(uvr), .over_voltage_i(ovr), .reg_on_i(on),
      .reg_in_regulation_i(ok), .ref_mismatch_i(refb), .system_on_i(sys), .low_trip_pct_o(lp),
      .high_trip_pct_o(hp), .low_trip_state_o(ls), .high_trip_state_o(hs), .power_stage_off_o(soff),
      .buck_start_block_o(blk), .irq_out_n_o(irqn));
   rvs_reg_model #(.RAMP(40)) rvs_reg_model_i (.clk_i(clk_i), .en_i(en), .uv_i(uvc), .ov_i(ovc),
      .on_o(on), .ok_o(ok), .uvr_o(uvr), .ovr_o(ovr));
   always #4 clk_i = ~clk_i;
   task automatic end_of_test;
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle, held until ack
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("bus answer", 32'h1, n < 20);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic t_regs;
      rd(6'h00, 32'h2, "control reset");
      rd(6'h04, 32'h7ff, "enables reset");
      rd(6'h20, 32'h0, "unmapped");
   endtask
   task automatic t_pct;
      logic [1:0] c;
      for (int i = 0; i < 4; i++)
      begin
         c = i[1:0];
         bl <= {7{c}};
         ll <= {4{c}};
         bh <= {7{c}};
         lh <= {4{c}};
         repeat (3) @(posedge clk_i);
         chk("low pct", {18'h0, 7'h5f - {4'h0, c, 1'b0}, 7'h5f - {4'h0, c, 1'b0}}, {18'h0, lp[6:0], lp[76:70]});
         chk("high pct", {18'h0, 7'h69 + {4'h0, c, 1'b0}, 7'h69 + {4'h0, c, 1'b0}}, {18'h0, hp[6:0], hp[76:70]});
      end
   endtask
   task automatic t_filt(input logic ov);
      int n;
      int nt;
      logic [31:0] q;
      for (int s = 0; s < 4; s++)
      begin
         nt = ov ? OVT[s] : UVT[s];
         wb(1'b1, 6'h00, 32'(ov ? s << 2 : s), q);
         ovc <= ov ? 11'h8 : 11'h0;
         uvc <= ov ? 11'h0 : 11'h8;
         n = 0;
         while ((ov ? hs[3] : ls[3]) !== 1'b1 && n < 300)
         begin
            @(posedge clk_i);
            n++;
         end
         chk("early", 32'h1, n > (nt - 1) * DIV);
         chk("late", 32'h1, n <= nt * DIV + 8);
         chk("others", 32'h0, (ov ? hs : ls) & 11'h7f7);
         uvc <= 11'h0;
         ovc <= 11'h0;
         repeat (10) @(posedge clk_i);
         chk("released", 32'h0, {ls[3], hs[3]});
      end
   endtask
   task automatic t_mask;
      logic [31:0] q;
      en <= 11'h7df;
      uvc <= 11'h20;
      repeat (60) @(posedge clk_i);
      chk("off masked", 32'h0, ls[5]);
      en <= 11'h7ff;
      repeat (30) @(posedge clk_i);
      chk("ramp masked", 32'h0, ls[5]);
      repeat (40) @(posedge clk_i);
      chk("fault seen", 32'h1, ls[5]);
      wb(1'b1, 6'h04, 32'h7df, q);
      repeat (3) @(posedge clk_i);
      chk("disable", 32'h0, ls[5]);
      rd(6'h10, 32'h0, "low states");
      wb(1'b1, 6'h04, 32'h7ff, q);
      uvc <= 11'h0;
   endtask
   task automatic t_sec;
      logic [31:0] q;
      wb(1'b1, 6'h00, 32'h10, q);
      wb(1'b1, 6'h04, 32'h0, q);
      rd(6'h04, 32'h7ff, "plain write");
      wb(1'b1, 6'h0c, `RVS_UNLOCK_KEY, q);
      wb(1'b1, 6'h08, 32'h3ff, q);
      rd(6'h04, 32'h3ff, "secure write");
      wb(1'b1, 6'h08, 32'h7ff, q);
      rd(6'h04, 32'h3ff, "locked");
      wb(1'b1, 6'h0c, `RVS_UNLOCK_KEY, q);
      wb(1'b1, 6'h08, 32'h7ff, q);
      wb(1'b1, 6'h00, 32'h0, q);
   endtask
   task automatic t_ref;
      logic [31:0] q;
      sys <= 1'b1;
      refb <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk("irq low", 32'h0, irqn);
      rd(6'h18, 32'h3, "mismatch on");
      wb(1'b1, 6'h18, 32'h4, q);
      repeat (2) @(posedge clk_i);
      chk("irq masked", 32'h1, irqn);
      refb <= 1'b0;
      repeat (12) @(posedge clk_i);
      wb(1'b1, 6'h18, 32'h6, q);
      rd(6'h18, 32'h4, "mismatch gone");
      sys <= 1'b0;
      refb <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk("block", 32'h1, {soff, blk});
      nf <= 1'b0;
      sys <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk("shut down", 32'h1, soff);
   endtask
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      t_regs();
      t_pct();
      t_filt(1'b0);
      t_filt(1'b1);
      t_mask();
      t_sec();
      t_ref();
      end_of_test();
   end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
endmodule
